// [shared/mdvit_pkg.sv]
package mdvit_pkg;
  // Array geometry and pixel code width
  localparam int         COL_N      = 680;
  localparam int         CODE_W     = 10;
  localparam int         ROW_W      = 10;
  // Ramp rises over 480 pixel clocks, counts 0..479
  localparam logic [9:0] RAMP_LAST  = 10'h01df;
  localparam logic [17:0] RAMP_DIV  = 18'h0_01e0;
  // Ramp start delay after line sync, in pixel clocks
  localparam logic [9:0] DLY_SHORT  = 10'h0008;
  localparam logic [9:0] DLY_LONG   = 10'h0010;
  // Flyback durations, in pixel clocks
  localparam logic [9:0] FLY_SHORT  = 10'h0008;
  localparam logic [9:0] FLY_LONG   = 10'h0010;
  // Register byte offsets
  localparam logic [7:0] OFS_RAMP   = 8'h00;
  localparam logic [7:0] OFS_PEAK   = 8'h04;
  localparam logic [7:0] OFS_INMODE = 8'h08;
  localparam logic [7:0] OFS_SCAN   = 8'h0c;
  localparam logic [7:0] OFS_FIRST  = 8'h10;
  localparam logic [7:0] OFS_LAST   = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  // Field positions
  localparam int RC_DLY_BIT   = 0;
  localparam int RC_FLY_BIT   = 1;
  localparam int IM_EPOL_BIT  = 0;
  localparam int IM_FPOL_BIT  = 1;
  localparam int SF_INTL_BIT  = 0;
  localparam int SF_STER_BIT  = 1;
  localparam int SF_VDIR_BIT  = 2;
  localparam int SF_HDIR_BIT  = 3;
  localparam int SF_BLNK_BIT  = 4;
  localparam int ST_HOLD_BIT  = 10;
  localparam int ST_FLD_BIT   = 11;
  // Reset values
  localparam logic [1:0] RAMP_RST   = 2'h0;
  localparam logic [7:0] PEAK_RST   = 8'h80;
  localparam logic [1:0] INMODE_RST = 2'h0;
  localparam logic [4:0] SCAN_RST   = 5'h10;
  localparam logic [9:0] FIRST_RST  = 10'h0014;
  localparam logic [9:0] LAST_RST   = 10'h01f3;
  // Ramp sequencer states
  typedef enum logic [1:0] {
    RS_IDLE    = 2'b00,
    RS_DELAY   = 2'b01,
    RS_RISE    = 2'b10,
    RS_FLYBACK = 2'b11
  } mdvit_ramp_type;
endpackage

// [shared/mdvit_cfg_if.sv]
interface mdvit_cfg_if;
  logic       ramp_start_delay;     // Late ramp start
  logic       flyback_duration_sel; // Long flyback
  logic [7:0] ramp_peak_level;      // Ramp maximum
  logic       enable_polarity;      // 1: enable active high
  logic       field_polarity;       // Inverts field sense
  logic       interlace_select;     // 1: interlaced
  logic       stereo_select;        // 1: stereovision
  logic       vertical_direction;   // 1: bottom to top
  logic       horizontal_direction; // 1: right to left
  logic       array_blank_ctl;      // 1: array black
  logic [9:0] window_first_row;     // Window start row
  logic [9:0] window_last_row;      // Window end row
  logic [9:0] row_count;            // Rows loaded this frame
  logic       field_even;           // Current field is field 2
  logic       frame_hold;           // Frame acquisition held
  modport regs (
    output ramp_start_delay, flyback_duration_sel, ramp_peak_level,
    output enable_polarity, field_polarity, interlace_select,
    output stereo_select, vertical_direction, horizontal_direction,
    output array_blank_ctl, window_first_row, window_last_row,
    input  row_count, field_even, frame_hold
  );
  modport core (
    input  ramp_start_delay, flyback_duration_sel, ramp_peak_level,
    input  enable_polarity, field_polarity, interlace_select,
    input  stereo_select, vertical_direction, horizontal_direction,
    input  array_blank_ctl, window_first_row, window_last_row,
    output row_count, field_even, frame_hold
  );
endinterface

// [hdl/mdvit_sync.sv]
module mdvit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rst_b, // Sync reset, active low
  input  wire logic         ce,    // Clock enable
  input  wire logic [W-1:0] d,     // Asynchronous inputs
  output logic      [W-1:0] q      // Synchronised outputs
);
  logic [W-1:0] meta_r; // First stage, read only by q

  // Two-flop synchroniser per bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// [hdl/mdvit_ahb.sv]
module mdvit_ahb
  import mdvit_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        rst_b,     // Sync reset, active low
  input  wire logic        ce,        // Clock enable
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Always ready
  output logic             hresp,     // Always OKAY
  output logic      [31:0] hrdata,    // Read data
  mdvit_cfg_if.regs        cfg        // Configuration out
);
  logic       wr_pend_r; // Write data phase pending
  logic [7:0] wr_addr_r; // Latched write offset
  logic [1:0] ramp_r;    // Ramp control
  logic [7:0] peak_r;    // Ramp peak
  logic [1:0] inmode_r;  // Enable and field polarity
  logic [4:0] scan_r;    // Scan format
  logic [9:0] first_r;   // Window first row
  logic [9:0] last_r;    // Window last row

  // Address phase decode; only whole words are written
  wire logic sel_ok = hsel & htrans[1] & hready;
  wire logic wr_ok  = sel_ok & hwrite & (hsize == 3'h2);
  wire logic rd_ok  = sel_ok & ~hwrite;
  wire logic [7:0] ra = haddr[7:0];
  // Read mux, unmapped offsets read zero
  wire logic [31:0] rd_mux =
    (ra == OFS_RAMP)   ? {30'h0, ramp_r}   :
    (ra == OFS_PEAK)   ? {24'h0, peak_r}   :
    (ra == OFS_INMODE) ? {30'h0, inmode_r} :
    (ra == OFS_SCAN)   ? {27'h0, scan_r}   :
    (ra == OFS_FIRST)  ? {22'h0, first_r}  :
    (ra == OFS_LAST)   ? {22'h0, last_r}   :
    (ra == OFS_STAT)   ? {20'h0, cfg.field_even, cfg.frame_hold,
                          cfg.row_count} : 32'h0000_0000;
  // Data phase write strobes
  wire logic we_ramp  = wr_pend_r & (wr_addr_r == OFS_RAMP);
  wire logic we_peak  = wr_pend_r & (wr_addr_r == OFS_PEAK);
  wire logic we_in    = wr_pend_r & (wr_addr_r == OFS_INMODE);
  wire logic we_scan  = wr_pend_r & (wr_addr_r == OFS_SCAN);
  wire logic we_first = wr_pend_r & (wr_addr_r == OFS_FIRST);
  wire logic we_last  = wr_pend_r & (wr_addr_r == OFS_LAST);

  // Bus handshake; zero wait states, so ready never drops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_pend_r <= wr_ok;
      wr_addr_r <= ra;
      hrdata    <= rd_ok ? rd_mux : 32'h0000_0000;
    end
  end

  // Register file; power-up keeps the array black
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ramp_r   <= RAMP_RST;
      peak_r   <= PEAK_RST;
      inmode_r <= INMODE_RST;
      scan_r   <= SCAN_RST;   // [RQ13] [RQ17] [RQ24]
      first_r  <= FIRST_RST;  // [RQ15]
      last_r   <= LAST_RST;
    end else if (ce) begin
      if (we_ramp)  ramp_r   <= hwdata[1:0];
      if (we_peak)  peak_r   <= hwdata[7:0];
      if (we_in)    inmode_r <= hwdata[1:0];
      if (we_scan)  scan_r   <= hwdata[4:0];
      if (we_first) first_r  <= hwdata[9:0];
      if (we_last)  last_r   <= hwdata[9:0];
    end
  end

  // Field fan-out to the core
  assign cfg.ramp_start_delay     = ramp_r[RC_DLY_BIT];  // [RQ12]
  assign cfg.flyback_duration_sel = ramp_r[RC_FLY_BIT];
  assign cfg.ramp_peak_level      = peak_r;
  assign cfg.enable_polarity      = inmode_r[IM_EPOL_BIT];
  assign cfg.field_polarity       = inmode_r[IM_FPOL_BIT];
  assign cfg.interlace_select     = scan_r[SF_INTL_BIT];
  assign cfg.stereo_select        = scan_r[SF_STER_BIT]; // [RQ21]
  assign cfg.vertical_direction   = scan_r[SF_VDIR_BIT];
  assign cfg.horizontal_direction = scan_r[SF_HDIR_BIT];
  assign cfg.array_blank_ctl      = scan_r[SF_BLNK_BIT];
  assign cfg.window_first_row     = first_r;
  assign cfg.window_last_row      = last_r;
endmodule

// [hdl/mdvit_top.sv]
// Summary of operation
// RQ1 - Source drives 30-bit bus, green only used
// RQ2 - Source supplies both syncs and pixel clock
// RQ3 - Data-valid assertion starts loading one row
// RQ4 - Enable active only stereo or interlaced
// RQ5 - Source gamma-corrects through 256x10 lookup
// RQ6 - Source pads rows with 40 black pixels
// RQ7 - Load next row, copy all columns at line end
// RQ8 - Pixel clock captures data, advances column
// RQ9 - Data shown within two line periods
// RQ10 - Column code becomes ramp sample delay
// RQ11 - Ramp rises 480 pixel clocks after delay
// RQ12 - Delay bit, peak level, flyback select
// RQ13 - Array black until blank bit cleared
// RQ14 - Separate vertical and horizontal direction bits
// RQ15 - First/last row registers set window
// RQ16 - Source puts 20 leading dummy pixels
// RQ17 - Scan-mode bit, zero means progressive
// RQ18 - Interlaced fields carry 240 to 512 rows
// RQ19 - Field latched from enable at vsync fall
// RQ20 - Inactive enable masks both syncs live
// RQ21 - Stereo bit selects stereovision operation
// RQ22 - Opposite polarities share one stereo sync
// RQ23 - Stereo enable sampled at vsync fall
// RQ24 - Normal use: polarity zero, enable low
// RQ25 - Line sync resets column load pointer
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
module mdvit_top
  import mdvit_pkg::*;
#(
  parameter int COLS = COL_N // Array columns
) (
  input  wire logic            clk,            // 25 MHz system clock
  input  wire logic            rst_b,          // Sync reset, active low
  input  wire logic            ce,             // Clock enable
  input  wire logic            hsel,           // Bus select
  input  wire logic [31:0]     haddr,          // Bus address
  input  wire logic [1:0]      htrans,         // Bus transfer type
  input  wire logic            hwrite,         // Bus write
  input  wire logic [2:0]      hsize,          // Bus size
  input  wire logic [31:0]     hwdata,         // Bus write data
  input  wire logic            hready,         // Bus ready
  output logic                 hreadyout,      // Slave ready
  output logic                 hresp,          // Slave response
  output logic      [31:0]     hrdata,         // Slave read data
  input  wire logic            sclk,           // Pixel clock pin
  input  wire logic            hsync,          // Line sync, high pulse
  input  wire logic            vsync,          // Frame sync, high pulse
  input  wire logic            row_data_valid, // Pixel data valid
  input  wire logic            enable_pin,     // Stereo or field pin
  input  wire logic [29:0]     pix_bus,        // Three 10-bit channels
  output logic      [9:0]      row_select,     // Array row driven
  output logic                 row_enable,     // Row lit this line
  output logic      [COLS-1:0] column_sample,  // Column sample strobes
  output logic      [7:0]      ramp_dac,       // Ramp level code
  output logic                 ramp_active,    // Ramp rising
  output logic                 field_even      // Field 2 active
);
  mdvit_cfg_if cfg ();

  // Register slave
  mdvit_ahb u_ahb (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .cfg       (cfg)
  );

  // All pin inputs cross through two flops; only green is used
  logic [14:0] pin_s; // Synchronised pins
  mdvit_sync #(.W(15)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     ({sclk, hsync, vsync, row_data_valid, enable_pin,
             pix_bus[19:10]}),                           // [RQ1]
    .q     (pin_s)
  );

  wire logic              sclk_s = pin_s[14]; // Pixel clock
  wire logic              hs_s   = pin_s[13]; // Line sync
  wire logic              vs_s   = pin_s[12]; // Frame sync
  wire logic              de_s   = pin_s[11]; // Data valid
  wire logic              en_s   = pin_s[10]; // Enable pin
  wire logic [CODE_W-1:0] grn_s  = pin_s[9:0];

  logic           sclk_p_r;  // Pixel clock last cycle
  logic           hs_p_r;    // Line sync at last pixel edge
  logic           vs_p_r;    // Frame sync at last pixel edge
  logic           de_p_r;    // Data valid at last pixel edge
  logic           hold_r;    // Stereo frame held
  logic           line_has_r;// Row received data
  logic [9:0]     load_ptr_r;// Column load pointer
  logic [9:0]     row_idx_r; // Rows loaded since frame start
  logic [CODE_W-1:0] load_mem [COLS]; // Row being loaded
  logic [CODE_W-1:0] disp_mem [COLS]; // Row being converted
  mdvit_ramp_type ramp_st;   // Ramp sequencer state
  mdvit_ramp_type ramp_st_nxt;
  logic [9:0]     ramp_cnt;  // Shared delay/ramp/flyback count
  logic [9:0]     ramp_cnt_nxt;

  // Edge detection on the pixel clock, sampled at its rising edge
  wire logic pix_tick = sclk_s & ~sclk_p_r;                 // [RQ8]
  wire logic hs_rise  = pix_tick & hs_s & ~hs_p_r;
  wire logic vs_fall  = pix_tick & ~vs_s & vs_p_r;
  wire logic de_rise  = pix_tick & de_s & ~de_p_r;
  // Enable level against programmed polarity
  wire logic en_active = ~(en_s ^ cfg.enable_polarity);    // [RQ24]
  // Live mask plus held frame; display keeps old image meanwhile
  wire logic mask_rt = cfg.stereo_select & ~en_active;      // [RQ20]
  wire logic gate_ok = ~mask_rt & ~hold_r;                  // [RQ22]
  wire logic hs_go   = hs_rise & gate_ok;
  wire logic vs_go   = vs_fall & gate_ok;
  wire logic de_go   = pix_tick & de_s & gate_ok;
  wire logic wr_en   = de_go & (load_ptr_r < 10'(COLS));
  // Horizontal scan direction mirrors the load position
  wire logic [9:0] wr_idx = cfg.horizontal_direction      // [RQ14]
                          ? 10'(COLS - 1) - load_ptr_r : load_ptr_r;
  // Row placement in window; field 2 takes the odd offsets
  wire logic [9:0] row_off = cfg.interlace_select         // [RQ17]
                           ? {row_idx_r[8:0], field_even} : row_idx_r;
  wire logic [9:0] row_span = cfg.window_last_row - cfg.window_first_row;
  wire logic [9:0] row_pos  = cfg.vertical_direction      // [RQ14]
                            ? cfg.window_last_row - row_off
                            : cfg.window_first_row + row_off; // [RQ15]
  wire logic row_in = line_has_r & (row_off <= row_span);
  // Ramp timing selections
  wire logic [9:0] dly_tgt = cfg.ramp_start_delay
                           ? DLY_LONG : DLY_SHORT;          // [RQ12]
  wire logic [9:0] fly_tgt = cfg.flyback_duration_sel
                           ? FLY_LONG : FLY_SHORT;          // [RQ12]
  // Ramp level scaled to the programmed peak
  wire logic [17:0] ramp_prod = 18'(ramp_cnt) * 18'(cfg.ramp_peak_level);
  wire logic [17:0] ramp_quot = ramp_prod / RAMP_DIV;
  wire logic [7:0]  ramp_lvl  = ramp_quot[7:0];             // [RQ12]
  // Blank or unlit rows sample at ramp zero, i.e. black
  wire logic dark = cfg.array_blank_ctl | ~row_enable;      // [RQ13]
  wire logic rise_tick = (ramp_st == RS_RISE) & pix_tick;
  wire logic [COLS-1:0] col_hit; // Per-column sample moment

  // Per-column delay compare: code*480/1024 ramp counts
  for (genvar c = 0; c < COLS; c++) begin : g_col
    wire logic [13:0] c15 = {disp_mem[c], 4'h0} - {4'h0, disp_mem[c]};
    assign col_hit[c] = rise_tick & (dark ? (ramp_cnt == 10'h000)
                        : ({1'b0, c15[13:5]} == ramp_cnt)); // [RQ10]
  end

  // Pin history; clock every cycle, syncs and valid at each pixel edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclk_p_r <= 1'b0;
      hs_p_r   <= 1'b0;
      vs_p_r   <= 1'b0;
      de_p_r   <= 1'b0;
    end else if (ce) begin
      sclk_p_r <= sclk_s;
      if (pix_tick) begin
        hs_p_r <= hs_s;
        vs_p_r <= vs_s;
        de_p_r <= de_s;
      end
    end
  end

  // Frame-start sampling of the enable pin; uses raw sync edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_r     <= 1'b0;
      field_even <= 1'b0;
    end else if (ce && vs_fall) begin
      hold_r <= cfg.stereo_select & ~en_active;             // [RQ23]
      if (cfg.interlace_select) begin
        field_even <= en_s ^ cfg.field_polarity;            // [RQ19]
      end
    end
  end

  // Column load pointer and row bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      load_ptr_r <= 10'h000;
      line_has_r <= 1'b0;
      row_idx_r  <= 10'h000;
    end else if (ce) begin
      if (hs_go) begin
        load_ptr_r <= 10'h000;                              // [RQ25]
        line_has_r <= 1'b0;
        row_idx_r  <= row_idx_r + {9'h000, line_has_r};
      end else begin
        if (de_rise && gate_ok) line_has_r <= 1'b1;         // [RQ3]
        if (wr_en) load_ptr_r <= load_ptr_r + 10'h001;      // [RQ8]
      end
      if (vs_go) row_idx_r <= 10'h000;
    end
  end

  // Load row capture; no reset needed for pixel storage
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      load_mem[wr_idx] <= grn_s;                            // [RQ8]
    end
  end

  // Line end: whole row moves to the conversion memory at once
  always_ff @(posedge clk) begin
    if (ce && hs_go) begin
      disp_mem <= load_mem;                                 // [RQ7]
    end
  end

  // Row driven next line; gives at most two lines of latency
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      row_select <= 10'h000;
      row_enable <= 1'b0;
    end else if (ce && hs_go) begin
      row_select <= row_pos;                                // [RQ9]
      row_enable <= row_in & ~cfg.array_blank_ctl;          // [RQ13]
    end
  end

  // Ramp sequencer: delay, 480-count rise, flyback
  always_comb begin
    ramp_st_nxt  = ramp_st;
    ramp_cnt_nxt = ramp_cnt;
    if (hs_go) begin
      ramp_st_nxt  = RS_DELAY;
      ramp_cnt_nxt = 10'h000;
    end else if (pix_tick) begin
      ramp_cnt_nxt = ramp_cnt + 10'h001;
      case (ramp_st)
        RS_DELAY: begin
          if (ramp_cnt == dly_tgt) begin
            ramp_st_nxt  = RS_RISE;                         // [RQ11]
            ramp_cnt_nxt = 10'h000;
          end
        end
        RS_RISE: begin
          if (ramp_cnt == RAMP_LAST) begin
            ramp_st_nxt  = RS_FLYBACK;                      // [RQ11]
            ramp_cnt_nxt = 10'h000;
          end
        end
        RS_FLYBACK: begin
          if (ramp_cnt == fly_tgt) begin
            ramp_st_nxt  = RS_IDLE;
            ramp_cnt_nxt = 10'h000;
          end
        end
        default: begin
          ramp_cnt_nxt = 10'h000; // Idle until next line
        end
      endcase
    end
  end

  // Ramp state and outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ramp_st       <= RS_IDLE;
      ramp_cnt      <= 10'h000;
      ramp_dac      <= 8'h00;
      ramp_active   <= 1'b0;
      column_sample <= '0;
    end else if (ce) begin
      ramp_st       <= ramp_st_nxt;
      ramp_cnt      <= ramp_cnt_nxt;
      ramp_dac      <= (ramp_st == RS_RISE) ? ramp_lvl : 8'h00;
      ramp_active   <= ramp_st_nxt == RS_RISE;
      column_sample <= col_hit;                             // [RQ10]
    end
  end

  // Status back to the register file
  assign cfg.row_count  = row_idx_r;
  assign cfg.field_even = field_even;
  assign cfg.frame_hold = hold_r;

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b || !ce);

  chk_ptr_line_start: assert property ( // [RQ25]
    hs_go |=> load_ptr_r == 10'h000) else $error("pointer not cleared");
  chk_first_load: assert property ( // [RQ3]
    de_rise && gate_ok && !hs_go |=> line_has_r)
    else $error("row load not started");
  chk_pixel_step: assert property ( // [RQ8]
    wr_en && !hs_go |=> load_ptr_r == $past(load_ptr_r) + 10'h001)
    else $error("pointer did not advance");
  chk_line_copy: assert property ( // [RQ7]
    hs_go |=> disp_mem[0] == $past(load_mem[0])
          && disp_mem[COLS-1] == $past(load_mem[COLS-1]))
    else $error("line copy missed");
  chk_ramp_length: assert property ( // [RQ11]
    rise_tick && ramp_cnt == RAMP_LAST && !hs_go
    |=> ramp_st == RS_FLYBACK) else $error("ramp length wrong");
  chk_ramp_delay: assert property ( // [RQ12]
    ramp_st == RS_DELAY && pix_tick && !hs_go && ramp_cnt == dly_tgt
    |=> ramp_st == RS_RISE && ramp_cnt == 10'h000)
    else $error("ramp delay wrong");
  chk_blank_dark: assert property ( // [RQ13]
    $past(cfg.array_blank_ctl) && column_sample != '0
    |-> $past(ramp_cnt) == 10'h000) else $error("blank not black");
  chk_mask_sync: assert property ( // [RQ20]
    mask_rt && hs_rise |=> row_idx_r == $past(row_idx_r)
                        && load_ptr_r >= $past(load_ptr_r))
    else $error("masked sync acted");
  chk_field_latch: assert property ( // [RQ19]
    vs_fall && cfg.interlace_select
    |=> field_even == $past(en_s ^ cfg.field_polarity))
    else $error("field not latched");
  chk_stereo_hold: assert property ( // [RQ23]
    vs_fall && cfg.stereo_select |=> hold_r == $past(!en_active))
    else $error("stereo hold wrong");
  chk_row_window: assert property ( // [RQ15]
    hs_go && !cfg.interlace_select && !cfg.vertical_direction
    |=> row_select == $past(cfg.window_first_row + row_idx_r))
    else $error("row position wrong");

  cov_line_lit:  cover property (hs_go && row_in && !dark);
  cov_flyback:   cover property (ramp_st == RS_FLYBACK && pix_tick);
  cov_field_two: cover property (cfg.interlace_select && field_even);
  cov_held:      cover property (hold_r && hs_rise);
endmodule

// [tb/mdvit_src.sv]
module mdvit_src (
  input  wire logic        clk,  // System clock
  input  wire logic        run,  // Frame in progress
  input  wire logic [3:0]  ctl,  // Wanted {enable, valid, vsync, hsync}
  input  wire logic [9:0]  code, // Green code to send
  output logic             sclk, // Pixel clock, still when idle
  output logic      [3:0]  pins, // Driven {enable, valid, vsync, hsync}
  output logic      [29:0] pix   // Pixel bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_r = 2'h0; // Half period counter, four clocks per pixel clock phase
  initial begin
    sclk = 1'b0;
    pins = 4'h0;
    pix  = 30'h0;
  end
  // Launch on falling pixel clock so the display sees full setup time
  always @(posedge clk) begin
    if (run || sclk) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        sclk <= ~sclk;
        if (sclk) begin
          pins <= ctl;
          // Idle bus toggles so a stale value never looks valid
          pix <= ctl[2] ? {~code, code, ~code} : ~pix;
        end
      end
    end
  end
endmodule

// [tb/tb_microdisplay_video_input_timing.sv]
module tb_microdisplay_video_input_timing
  import mdvit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;     // 25 MHz clock
  logic             rst_b = 1'b0;   // Reset, active low
  logic             hsel = 1'b0;    // Bus select
  logic      [1:0]  htrans = 2'h0;  // Transfer type
  logic      [31:0] haddr = 32'h0;  // Address
  logic             hwrite = 1'b0;  // Write flag
  logic      [31:0] hwdata = 32'h0; // Write data
  logic             run = 1'b0;     // Pixel clock on
  logic      [3:0]  ctl = 4'h0;     // Source controls
  logic      [9:0]  code = 10'h0;   // Source code
  logic      [31:0] rd_s;           // Read data at data phase end
  logic             hreadyout, hresp, sclk, row_enable, ramp_active;
  logic             field_even;     // Field 2 flag
  logic      [31:0] hrdata;         // Read data
  logic      [3:0]  pins;           // Source pins
  logic      [29:0] pix;            // Pixel bus
  logic      [9:0]  row_select;     // Row driven
  logic      [7:0]  ramp_dac;       // Ramp level
  logic      [COL_N-1:0] column_sample; // Column strobes
  int               bad_count = 0;  // Mismatches
  int               n_compared = 0; // Comparisons
  always #20 clk = ~clk;
  always @(posedge clk) rd_s <= hrdata;
  mdvit_src src_u (.clk(clk), .run(run), .ctl(ctl), .code(code),
    .sclk(sclk), .pins(pins), .pix(pix));
  mdvit_top #(.COLS(COL_N)) dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk(sclk),
    .hsync(pins[0]), .vsync(pins[1]), .row_data_valid(pins[2]),
    .enable_pin(pins[3]), .pix_bus(pix), .row_select(row_select),
    .row_enable(row_enable), .column_sample(column_sample),
    .ramp_dac(ramp_dac), .ramp_active(ramp_active), .field_even(field_even));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // Single word transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, w};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'b00, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    #1 rd = rd_s;
  endtask
  task automatic ticks(input int n);
    repeat (n * 8) @(posedge clk);
  endtask
  task automatic frame;
    {run, ctl[1]} <= 2'b11;
    ticks(2);
    ctl[1] <= 1'b0;
    ticks(6);
  endtask
  task automatic line(input logic [9:0] c);
    {code, ctl[2]} <= {c, 1'b1};
    ticks(COL_N);
    ctl[2] <= 1'b0;
    ticks(14);
    ctl[0] <= 1'b1;
    ticks(4);
    ctl[0] <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic [7:0]  ofs [0:6];
    logic [31:0] want [0:6];
    ofs = '{OFS_RAMP, OFS_PEAK, OFS_INMODE, OFS_SCAN, OFS_FIRST, OFS_LAST,
            8'h1c};
    want = '{32'(RAMP_RST), 32'(PEAK_RST), 32'(INMODE_RST), 32'(SCAN_RST),
             32'(FIRST_RST), 32'(LAST_RST), 32'h0000_0000};
    bus(1'b1, 8'h1c, 32'hffff_ffff, r);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ofs[i], 32'h0, r);
      chk(r, want[i]);
    end
    chk({hreadyout, hresp}, 2'b10);
    $display("register test done");
  endtask
  task automatic t_ramp;
    logic [31:0] r;
    int          n;
    int          c0;
    int          p_last;
    logic [7:0]  dac;
    bus(1'b1, OFS_SCAN, 32'h0000_0000, r);
    frame();
    line(10'h0200);
    n = 0;
    while (ramp_active !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(row_select, FIRST_RST);
    chk(row_enable, 1'b1);
    {n, c0, p_last} = 96'h0;
    while (ramp_active === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
      if (column_sample[0] === 1'b1) c0 = n;
      if (column_sample[0] === 1'b1) dac = ramp_dac;
      if (column_sample[COL_N-1] === 1'b1) p_last++;
    end
    run <= 1'b0;
    chk(n, 480 * 8);
    chk(c0 >= 1912 && c0 <= 1928, 1'b1);
    chk(p_last, 1);
    chk(dac, PEAK_RST / 2);
    $display("ramp test done");
  endtask
  task automatic t_modes;
    logic [31:0] r;
    bus(1'b1, OFS_INMODE, 32'h0000_0000, r);
    bus(1'b1, OFS_SCAN, 32'h0000_0002, r);
    ctl[3] <= 1'b1;
    frame();
    // Masked line sync must leave the lit row alone
    ctl[0] <= 1'b1;
    ticks(4);
    ctl[0] <= 1'b0;
    chk(row_enable, 1'b1);
    bus(1'b0, OFS_STAT, 32'h0, r);
    chk(r[ST_HOLD_BIT], 1'b1);
    ctl[3] <= 1'b0;
    frame();
    bus(1'b0, OFS_STAT, 32'h0, r);
    chk(r[ST_HOLD_BIT], 1'b0);
    bus(1'b1, OFS_SCAN, 32'h0000_0015, r);
    ctl[3] <= 1'b1;
    frame();
    chk(field_even, 1'b1);
    bus(1'b1, OFS_INMODE, 32'h0000_0002, r);
    frame();
    chk(field_even, 1'b0);
    line(10'h03ff);
    chk(row_enable, 1'b0);
    chk(row_select, LAST_RST);
    // Blanked row: every column samples at ramp zero
    for (int i = 0; i < 200 && column_sample[0] !== 1'b1; i++)
      @(negedge clk);
    chk(column_sample[COL_N-1], 1'b1);
    $display("mode test done");
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog sized well above the roughly 15500 cycles of traffic
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_ramp();
    t_modes();
    print_verdict();
  end
endmodule
